// *** verilog/mcutf_core.sv ***
// Instruction sequencer, program counter, return stack and accumulator
`timescale 1ns/1ps
// Notes on behaviour
// - An instruction cycle is four system clocks; all timing counts these.
// - Plain instructions take one cycle; branch, call, table read take two.
// - Jump, call, subroutine exit and interrupt exit add one cycle.
// - Writing the program counter low byte jumps there and adds one cycle.
// - A skip test costs one cycle, plus one more when it skips.
// - Moves: register to acc, acc to register, immediate to acc.
// - Add sets carry above 255; subtract flags borrow below zero.
// - Increment and decrement by one, to memory or to the accumulator.
// - Logic results set zero flag when zero, clear it otherwise.
// - Register moves pass through the accumulator; no memory to memory move.
// - Rotates move one bit; through-carry forms send outgoing bit to carry.
// - Call saves the next address; subroutine exit resumes there.
// - Jump loads the target and saves no return address.
// - Conditional branches test memory or a bit, then run or skip next.
module mcutf_core (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Program memory fetch
	output logic [10:0] prog_addr,
	input wire logic [15:0] prog_data,
	// Data memory
	output logic [7:0] dmem_addr,
	input wire logic [7:0] dmem_rdata,
	output logic [7:0] dmem_wdata,
	output logic dmem_we,
	// Status
	output logic [7:0] acc_out,
	output logic carry_flag,
	output logic zero_flag,
	output logic cycle_strobe,
	output logic stack_overflow
);
	logic [1:0] phase;
	logic cycle_end;
	mcutf_pkg::mcutf_state_e state;
	mcutf_pkg::mcutf_state_e next_state;
	logic [10:0] pc;
	logic [10:0] next_pc;
	logic [7:0] acc;
	logic [15:0] insn;
	logic [4:0] op;
	logic [7:0] operand;
	logic [2:0] bit_sel;
	logic [10:0] stack [mcutf_pkg::STACK_DEPTH];
	logic [2:0] sp;
	logic push;
	logic pop;
	logic take_skip;
	logic mem_write;
	logic acc_write;
	logic pc_low_write;
	logic [7:0] alu_result;
	logic alu_carry;
	logic alu_carry_we;
	logic alu_zero;
	logic alu_zero_we;
	logic [10:0] pc_inc;

	assign insn = prog_data;
	assign op = insn[mcutf_pkg::OP_HI:mcutf_pkg::OP_LO];
	assign operand = insn[7:0];
	assign bit_sel = insn[mcutf_pkg::BIT_HI:mcutf_pkg::BIT_LO];
	assign pc_inc = pc + 11'h001;

	// Phase counter marks the last clock of each instruction cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= mcutf_pkg::PHASE_RESET;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	assign cycle_end = (phase == mcutf_pkg::PHASE_LAST);

	// Shared datapath; memory operand combines with acc for add, subtract, and, or, xor
	mcutf_alu u_alu (
		.op(op),
		.acc(acc),
		.mem(dmem_rdata),
		.imm(operand),
		.carry_in(carry_flag),
		.result(alu_result),
		.carry_out(alu_carry),
		.carry_we(alu_carry_we),
		.zero_out(alu_zero),
		.zero_we(alu_zero_we)
	);

	// Classify destination of the executing instruction
	always_comb begin
		mem_write = 1'b0;
		acc_write = 1'b0;
		take_skip = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		unique case (op)
			mcutf_pkg::OP_XFER_AM, mcutf_pkg::OP_ADDM, mcutf_pkg::OP_SUBM,
			mcutf_pkg::OP_COMP, mcutf_pkg::OP_INC, mcutf_pkg::OP_DCR,
			mcutf_pkg::OP_ROTR, mcutf_pkg::OP_ROTL, mcutf_pkg::OP_ROTRC,
			mcutf_pkg::OP_ROTLC: mem_write = 1'b1;
			mcutf_pkg::OP_XFER_MA, mcutf_pkg::OP_XFER_XA, mcutf_pkg::OP_ADD,
			mcutf_pkg::OP_SUB, mcutf_pkg::OP_AND, mcutf_pkg::OP_OR,
			mcutf_pkg::OP_XOR, mcutf_pkg::OP_COMP_ACC, mcutf_pkg::OP_INC_ACC,
			mcutf_pkg::OP_DCR_ACC, mcutf_pkg::OP_ADDX, mcutf_pkg::OP_SUBX,
			mcutf_pkg::OP_ANDX: acc_write = 1'b1;
			mcutf_pkg::OP_SZ: take_skip = (dmem_rdata == 8'h00);
			mcutf_pkg::OP_SNZ_BIT: take_skip = dmem_rdata[bit_sel];
			mcutf_pkg::OP_SZ_BIT: take_skip = ~dmem_rdata[bit_sel];
			mcutf_pkg::OP_CALL: push = 1'b1;
			mcutf_pkg::OP_SUB_EXIT, mcutf_pkg::OP_IRET: pop = 1'b1;
			default: begin
			end
		endcase
		pc_low_write = mem_write && (operand == mcutf_pkg::PC_LOW_ADDR);
	end

	// Next program counter and next cycle slot
	always_comb begin
		next_pc = pc_inc;
		next_state = mcutf_pkg::ST_EXEC;
		unique case (state)
			mcutf_pkg::ST_EXEC: begin
				if (op == mcutf_pkg::OP_JUMP || op == mcutf_pkg::OP_CALL) begin
					next_pc = insn[10:0];
					next_state = mcutf_pkg::ST_FLUSH;
				end else if (pop) begin
					next_pc = stack[sp - 3'h1];
					next_state = mcutf_pkg::ST_FLUSH;
				end else if (pc_low_write) begin
					next_pc = {pc[10:8], alu_result};
					next_state = mcutf_pkg::ST_FLUSH;
				end else if (take_skip) begin
					next_pc = pc + 11'h002;
					next_state = mcutf_pkg::ST_FLUSH;
				end else if (op == mcutf_pkg::OP_TABRD) begin
					next_pc = pc;
					next_state = mcutf_pkg::ST_TABLE;
				end
			end
			mcutf_pkg::ST_FLUSH: next_pc = pc;
			mcutf_pkg::ST_TABLE: next_pc = pc_inc;
			default: next_pc = pc;
		endcase
	end

	// Sequencer advances once per instruction cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= mcutf_pkg::ST_EXEC;
		end else if (cycle_end) begin
			state <= next_state;
		end
	end

	// Program counter; the flush slot idles so the redirect costs one cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc <= mcutf_pkg::PC_RESET;
		end else if (cycle_end && state == mcutf_pkg::ST_EXEC) begin
			pc <= next_pc;
		end else if (cycle_end && state == mcutf_pkg::ST_TABLE) begin
			pc <= next_pc;
		end
	end

	// Return stack; wraps on overflow like a ring, flagged for software
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sp <= mcutf_pkg::SP_RESET;
			stack_overflow <= 1'b0;
		end else if (cycle_end && state == mcutf_pkg::ST_EXEC) begin
			if (push) begin
				sp <= sp + 3'h1;
				if (sp == 3'h7) begin
					stack_overflow <= 1'b1;
				end
			end else if (pop) begin
				sp <= sp - 3'h1;
			end
		end
	end

	// Stack storage has no reset; an entry is always pushed before it is read
	always_ff @(posedge sys_clk) begin
		if (cycle_end && state == mcutf_pkg::ST_EXEC && push) begin
			stack[sp] <= pc_inc;
		end
	end

	// Accumulator and flags; only ALU results reach them
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc <= mcutf_pkg::ACC_RESET;
			carry_flag <= 1'b0;
			zero_flag <= 1'b0;
		end else if (cycle_end && state == mcutf_pkg::ST_EXEC) begin
			if (acc_write) begin
				acc <= alu_result;
			end
			if (alu_carry_we) begin
				carry_flag <= alu_carry;
			end
			if (alu_zero_we) begin
				zero_flag <= alu_zero;
			end
		end
	end

	// Registered outputs toward memories and status
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prog_addr <= mcutf_pkg::PC_RESET;
			dmem_addr <= 8'h00;
			dmem_wdata <= 8'h00;
			dmem_we <= 1'b0;
			cycle_strobe <= 1'b0;
			acc_out <= mcutf_pkg::ACC_RESET;
		end else begin
			prog_addr <= (state == mcutf_pkg::ST_TABLE) ? {3'h0, acc} : pc;
			dmem_addr <= operand;
			dmem_wdata <= (op == mcutf_pkg::OP_XFER_AM) ? acc : alu_result;
			dmem_we <= cycle_end && state == mcutf_pkg::ST_EXEC && mem_write;
			cycle_strobe <= cycle_end;
			acc_out <= acc;
		end
	end
endmodule

// *** inc/mcutf_pkg.sv ***
// Package of constants and types for the instruction timing and flow core
package mcutf_pkg;
	// Widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 11;
	localparam int INSN_W = 16;
	localparam int DMEM_ADDR_W = 8;
	// Instruction cycle in system clocks and phase counter
	localparam int CLKS_PER_CYCLE = 4;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	// Return stack depth and pointer width
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 3;
	// Reset values
	localparam logic [10:0] PC_RESET = 11'h000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [2:0] SP_RESET = 3'h0;
	// Data memory address of the program counter low byte
	localparam logic [7:0] PC_LOW_ADDR = 8'h06;
	// Opcode field positions
	localparam int OP_HI = 15;
	localparam int OP_LO = 11;
	localparam int BIT_HI = 10;
	localparam int BIT_LO = 8;
	// Opcode encoding of the 5-bit major field (own encoding)
	typedef enum logic [4:0] {
		OP_NOP      = 5'h00,
		OP_XFER_MA  = 5'h01, // register to accumulator
		OP_XFER_AM  = 5'h02, // accumulator to register
		OP_XFER_XA  = 5'h03, // immediate to accumulator
		OP_ADD      = 5'h04,
		OP_ADDM     = 5'h05,
		OP_SUB      = 5'h06,
		OP_SUBM     = 5'h07,
		OP_AND      = 5'h08,
		OP_OR       = 5'h09,
		OP_XOR      = 5'h0a,
		OP_COMP     = 5'h0b,
		OP_COMP_ACC = 5'h0c,
		OP_INC      = 5'h0d,
		OP_INC_ACC  = 5'h0e,
		OP_DCR      = 5'h0f,
		OP_DCR_ACC  = 5'h10,
		OP_ROTR     = 5'h11,
		OP_ROTL     = 5'h12,
		OP_ROTRC    = 5'h13,
		OP_ROTLC    = 5'h14,
		OP_SZ       = 5'h15, // skip if memory zero
		OP_SNZ_BIT  = 5'h16, // skip if bit set
		OP_SZ_BIT   = 5'h17, // skip if bit clear
		OP_JUMP     = 5'h18,
		OP_CALL     = 5'h19,
		OP_SUB_EXIT = 5'h1a,
		OP_IRET     = 5'h1b,
		OP_TABRD    = 5'h1c,
		OP_ADDX     = 5'h1d,
		OP_SUBX     = 5'h1e,
		OP_ANDX     = 5'h1f
	} mcutf_op_e;
	// Sequencer states, one per instruction cycle slot
	typedef enum logic [1:0] {
		ST_EXEC  = 2'b00,
		ST_FLUSH = 2'b01,
		ST_TABLE = 2'b10
	} mcutf_state_e;
endpackage

// *** verilog/mcutf_alu.sv ***
// Arithmetic and logic unit of the core
`timescale 1ns/1ps
module mcutf_alu (
	// Operation and operands
	input wire logic [4:0] op,
	input wire logic [7:0] acc,
	input wire logic [7:0] mem,
	input wire logic [7:0] imm,
	input wire logic carry_in,
	// Results
	output logic [7:0] result,
	output logic carry_out,
	output logic carry_we,
	output logic zero_out,
	output logic zero_we
);
	logic [8:0] wide;

	// One combinational datapath, result always heads for acc or memory
	always_comb begin
		wide = 9'h000;
		result = acc;
		carry_out = carry_in;
		carry_we = 1'b0;
		zero_we = 1'b1;
		unique case (op)
			mcutf_pkg::OP_ADD, mcutf_pkg::OP_ADDM, mcutf_pkg::OP_ADDX: begin
				wide = {1'b0, acc} + {1'b0, (op == mcutf_pkg::OP_ADDX) ? imm : mem};
				result = wide[7:0];
				carry_out = wide[8];
				carry_we = 1'b1;
			end
			mcutf_pkg::OP_SUB, mcutf_pkg::OP_SUBM, mcutf_pkg::OP_SUBX: begin
				wide = {1'b0, acc} - {1'b0, (op == mcutf_pkg::OP_SUBX) ? imm : mem};
				result = wide[7:0];
				carry_out = ~wide[8];
				carry_we = 1'b1;
			end
			mcutf_pkg::OP_AND: result = acc & mem;
			mcutf_pkg::OP_ANDX: result = acc & imm;
			mcutf_pkg::OP_OR: result = acc | mem;
			mcutf_pkg::OP_XOR: result = acc ^ mem;
			mcutf_pkg::OP_COMP, mcutf_pkg::OP_COMP_ACC: result = ~mem;
			mcutf_pkg::OP_INC, mcutf_pkg::OP_INC_ACC: result = mem + 8'h01;
			mcutf_pkg::OP_DCR, mcutf_pkg::OP_DCR_ACC: result = mem - 8'h01;
			mcutf_pkg::OP_ROTR: begin
				result = {mem[0], mem[7:1]};
				zero_we = 1'b0;
			end
			mcutf_pkg::OP_ROTL: begin
				result = {mem[6:0], mem[7]};
				zero_we = 1'b0;
			end
			mcutf_pkg::OP_ROTRC: begin
				result = {carry_in, mem[7:1]};
				carry_out = mem[0];
				carry_we = 1'b1;
				zero_we = 1'b0;
			end
			mcutf_pkg::OP_ROTLC: begin
				result = {mem[6:0], carry_in};
				carry_out = mem[7];
				carry_we = 1'b1;
				zero_we = 1'b0;
			end
			mcutf_pkg::OP_XFER_MA: begin
				result = mem;
				zero_we = 1'b0;
			end
			mcutf_pkg::OP_XFER_XA: begin
				result = imm;
				zero_we = 1'b0;
			end
			default: zero_we = 1'b0;
		endcase
		zero_out = (result == 8'h00);
	end
endmodule

// *** test/mcutf_core_asserts.sv ***
// Port timing checks for the instruction timing and flow core
`timescale 1ns/1ps
module mcutf_core_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Watched outputs
	input wire logic [10:0] prog_addr,
	input wire logic [7:0] acc_out,
	input wire logic dmem_we,
	input wire logic carry_flag,
	input wire logic zero_flag,
	input wire logic cycle_strobe,
	input wire logic stack_overflow
);
	// One clock domain, so clock and reset are stated once
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	strobe_period_a: assert property (
		cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe) else $error("strobe period");
	addr_hold_a: assert property (
		$changed(prog_addr) |=> $stable(prog_addr) [*3]) else $error("fetch address moved");
	acc_step_a: assert property (
		$changed(acc_out) |-> $past(cycle_strobe)) else $error("acc off boundary");
	we_strobe_a: assert property (
		dmem_we |-> cycle_strobe) else $error("write off boundary");
	we_once_a: assert property (
		dmem_we |=> !dmem_we [*3]) else $error("write too often");
	carry_hold_a: assert property (
		$changed(carry_flag) |=> $stable(carry_flag) [*3]) else $error("carry moved");
	zero_hold_a: assert property (
		$changed(zero_flag) |-> ##1 !$changed(zero_flag) [*3]) else $error("zero moved");
	ovf_sticky_a: assert property (
		stack_overflow |=> stack_overflow) else $error("overflow dropped");
endmodule

bind mcutf_core mcutf_core_chk mcutf_core_chk_inst (.sys_clk(sys_clk), .arst_n(arst_n),
	.prog_addr(prog_addr), .acc_out(acc_out), .dmem_we(dmem_we), .carry_flag(carry_flag),
	.zero_flag(zero_flag), .cycle_strobe(cycle_strobe), .stack_overflow(stack_overflow));

// *** test/mcutf_mem_model.sv ***
// Program and data memory model facing the core
`timescale 1ns/1ps
module mcutf_mem_model (
	// Clock
	input wire logic sys_clk,
	// Program fetch
	input wire logic [10:0] prog_addr,
	output logic [15:0] prog_data,
	// Data memory
	input wire logic [7:0] dmem_addr,
	output logic [7:0] dmem_rdata,
	input wire logic [7:0] dmem_wdata,
	input wire logic dmem_we
);
	logic [15:0] rom [2048];
	logic [7:0] ram [256];
	// Reads answer at once; the core samples late in its cycle
	assign prog_data = rom[prog_addr];
	assign dmem_rdata = ram[dmem_addr];
	// Write pulse lasts one clock
	always @(posedge sys_clk) begin
		if (dmem_we) begin
			ram[dmem_addr] <= dmem_wdata;
		end
	end
endmodule

// *** test/mcu_instruction_timing_flow_bench.sv ***
// Self-checking bench for the instruction timing and flow core
`timescale 1ns/1ps
module mcu_instruction_timing_flow_bench;
	logic sys_clk;
	logic arst_n;
	logic [10:0] prog_addr;
	logic [15:0] prog_data;
	logic [7:0] dmem_addr, dmem_rdata, dmem_wdata, acc_out;
	logic dmem_we, carry_flag, zero_flag, cycle_strobe, stack_overflow;
	int err_total = 0;
	int check_count = 0;
	// Core and its memories
	mcutf_core mcutf_core_inst (.sys_clk, .arst_n, .prog_addr, .prog_data, .dmem_addr,
		.dmem_rdata, .dmem_wdata, .dmem_we, .acc_out, .carry_flag, .zero_flag, .cycle_strobe,
		.stack_overflow);
	mcutf_mem_model mcutf_mem_model_inst (.sys_clk, .prog_addr, .prog_data, .dmem_addr,
		.dmem_rdata, .dmem_wdata, .dmem_we);
	// Clock at 200 MHz
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Memory access helpers
	task automatic pk(int a, mcutf_pkg::mcutf_op_e op, logic [10:0] v);
		mcutf_mem_model_inst.rom[a] = {op, v};
	endtask
	task automatic pd(int a, logic [7:0] v);
		mcutf_mem_model_inst.ram[a] = v;
	endtask
	function automatic logic [7:0] rd(int a);
		return mcutf_mem_model_inst.ram[a];
	endfunction
	// Hold reset first, so a running program cannot write while memories load
	task automatic clr();
		@(posedge sys_clk);
		arst_n <= 1'b0;
		@(posedge sys_clk);
		foreach (mcutf_mem_model_inst.rom[i]) mcutf_mem_model_inst.rom[i] = 16'h0000;
		foreach (mcutf_mem_model_inst.ram[i]) mcutf_mem_model_inst.ram[i] = 8'h00;
	endtask
	// Reset, then sample inside cycle n+1, after n cycles have committed
	task automatic run(int n);
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (4 * n + 2) @(posedge sys_clk);
		#1;
	endtask
	// Compare tasks
	task automatic cmp8(logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(logic got, logic exp);
		cmp8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic at(int n, logic [7:0] a);
		run(n);
		cmp8(acc_out, a);
	endtask
	// Moves, carry, borrow, increment and decrement
	task automatic t_arith();
		clr();
		pd(8'h10, 8'hf0);
		pd(8'h11, 8'h20);
		pk(0, mcutf_pkg::OP_XFER_MA, 11'h010);
		pk(1, mcutf_pkg::OP_ADD, 11'h011);
		pk(2, mcutf_pkg::OP_XFER_AM, 11'h012);
		pk(3, mcutf_pkg::OP_XFER_XA, 11'h005);
		pk(4, mcutf_pkg::OP_SUB, 11'h011);
		pk(5, mcutf_pkg::OP_INC, 11'h011);
		pk(6, mcutf_pkg::OP_DCR_ACC, 11'h010);
		pk(7, mcutf_pkg::OP_JUMP, 11'h007);
		at(2, 8'h10);
		cmp1(carry_flag, 1'b1);
		at(5, 8'he5);
		cmp1(carry_flag, 1'b0);
		cmp8(rd(8'h12), 8'h10);
		at(7, 8'hef);
		cmp8(rd(8'h11), 8'h21);
		$display("arith done");
	endtask
	// Logic with zero flag, rotates with and without carry
	task automatic t_logic();
		clr();
		pd(8'h20, 8'h0f);
		pd(8'h21, 8'hf0);
		pd(8'h22, 8'h03);
		pk(0, mcutf_pkg::OP_XFER_MA, 11'h020);
		pk(1, mcutf_pkg::OP_AND, 11'h021);
		pk(2, mcutf_pkg::OP_OR, 11'h021);
		pk(3, mcutf_pkg::OP_XOR, 11'h020);
		pk(4, mcutf_pkg::OP_COMP_ACC, 11'h021);
		pk(5, mcutf_pkg::OP_ROTRC, 11'h022);
		pk(6, mcutf_pkg::OP_ROTLC, 11'h022);
		pk(7, mcutf_pkg::OP_ROTR, 11'h022);
		pk(8, mcutf_pkg::OP_JUMP, 11'h008);
		at(2, 8'h00);
		cmp1(zero_flag, 1'b1);
		at(3, 8'hf0);
		cmp1(zero_flag, 1'b0);
		at(4, 8'hff);
		at(6, 8'h0f);
		cmp8(rd(8'h22), 8'h01);
		cmp1(carry_flag, 1'b1);
		// Each run restarts the program, so the rotated byte is restored first
		pd(8'h22, 8'h03);
		at(8, 8'h0f);
		cmp8(rd(8'h22), 8'h81);
		cmp1(carry_flag, 1'b0);
		$display("logic done");
	endtask
	// Call, then a subroutine or interrupt exit
	task automatic t_flow(mcutf_pkg::mcutf_op_e ex);
		clr();
		pk(0, mcutf_pkg::OP_CALL, 11'h00a);
		pk(1, mcutf_pkg::OP_XFER_XA, 11'h022);
		pk(2, mcutf_pkg::OP_JUMP, 11'h002);
		pk(10, mcutf_pkg::OP_XFER_XA, 11'h011);
		pk(11, ex, 11'h000);
		at(2, 8'h00);
		at(3, 8'h11);
		at(5, 8'h11);
		at(6, 8'h22);
		$display("flow done");
	endtask
	// Jump, write of the low address byte, skips taken and not, table read
	task automatic t_branch();
		clr();
		pd(8'h31, 8'h01);
		pk(0, mcutf_pkg::OP_JUMP, 11'h004);
		pk(1, mcutf_pkg::OP_XFER_XA, 11'h099);
		pk(4, mcutf_pkg::OP_XFER_XA, 11'h007);
		pk(5, mcutf_pkg::OP_XFER_AM, {3'h0, mcutf_pkg::PC_LOW_ADDR});
		pk(6, mcutf_pkg::OP_XFER_XA, 11'h066);
		pk(7, mcutf_pkg::OP_XFER_XA, 11'h000);
		pk(8, mcutf_pkg::OP_SZ, 11'h030);
		pk(9, mcutf_pkg::OP_XFER_XA, 11'h055);
		pk(10, mcutf_pkg::OP_SZ, 11'h031);
		pk(11, mcutf_pkg::OP_XFER_XA, 11'h033);
		pk(12, mcutf_pkg::OP_SNZ_BIT, 11'h031);
		pk(13, mcutf_pkg::OP_XFER_XA, 11'h044);
		pk(14, mcutf_pkg::OP_SZ_BIT, 11'h131);
		pk(15, mcutf_pkg::OP_XFER_XA, 11'h077);
		pk(16, mcutf_pkg::OP_SZ_BIT, 11'h031);
		pk(17, mcutf_pkg::OP_XFER_XA, 11'h012);
		pk(18, mcutf_pkg::OP_TABRD, 11'h000);
		pk(19, mcutf_pkg::OP_XFER_XA, 11'h021);
		pk(20, mcutf_pkg::OP_JUMP, 11'h014);
		at(2, 8'h00);
		at(3, 8'h07);
		at(5, 8'h07);
		at(6, 8'h00);
		at(9, 8'h00);
		at(10, 8'h33);
		at(14, 8'h33);
		at(16, 8'h12);
		at(17, 8'h12);
		cmp8(prog_addr[7:0], 8'h12);
		at(19, 8'h21);
		$display("branch done");
	endtask
	// Immediate forms, add to memory and increment into the accumulator
	task automatic t_imm();
		clr();
		pd(8'h40, 8'h05);
		pk(0, mcutf_pkg::OP_XFER_XA, 11'h0f0);
		pk(1, mcutf_pkg::OP_ADDX, 11'h020);
		pk(2, mcutf_pkg::OP_ADDM, 11'h040);
		pk(3, mcutf_pkg::OP_SUBX, 11'h011);
		pk(4, mcutf_pkg::OP_ANDX, 11'h00f);
		pk(5, mcutf_pkg::OP_INC_ACC, 11'h040);
		pk(6, mcutf_pkg::OP_JUMP, 11'h006);
		at(6, 8'h16);
		cmp8(rd(8'h40), 8'h15);
		cmp1(carry_flag, 1'b0);
		cmp1(zero_flag, 1'b0);
		$display("immediate done");
	endtask
	// Eight nested calls fill the return stack
	task automatic t_stack();
		clr();
		for (int i = 0; i < 8; i++) begin
			pk(i, mcutf_pkg::OP_CALL, 11'(i + 1));
		end
		pk(8, mcutf_pkg::OP_JUMP, 11'h008);
		run(14);
		cmp1(stack_overflow, 1'b0);
		run(16);
		cmp1(stack_overflow, 1'b1);
		$display("stack done");
	endtask
	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Whole run is about a thousand clocks; this cuts a hang short
	initial begin
		#50000;
		err_total++;
		wrap_up();
	end
	// Main sequence
	initial begin
		arst_n = 1'b0;
		t_arith();
		t_logic();
		t_imm();
		t_flow(mcutf_pkg::OP_SUB_EXIT);
		t_flow(mcutf_pkg::OP_IRET);
		t_branch();
		t_stack();
		wrap_up();
	end
endmodule
